// [design/cmpw_pkg.sv]
// Package for the dual comparator wrapper: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
package cmpw_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL0_OFF = 8'h00;
   localparam logic [7:0] MUX0_OFF = 8'h04;
   localparam logic [7:0] MODE0_OFF = 8'h08;
   localparam logic [7:0] CTRL1_OFF = 8'h10;
   localparam logic [7:0] MUX1_OFF = 8'h14;
   localparam logic [7:0] MODE1_OFF = 8'h18;
   localparam logic [7:0] PIN_OFF = 8'h20;
   localparam logic [7:0] RST_OFF = 8'h24;
   // Control register fields
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_OUT_BIT = 6;
   localparam int CTRL_RISE_BIT = 5;
   localparam int CTRL_FALL_BIT = 4;
   localparam int CTRL_HYS_LSB = 0;
   localparam int HYS_W = 4;
   // Mux register fields
   localparam int MUX_NEG_LSB = 0;
   localparam int MUX_POS_LSB = 4;
   localparam int SEL_W = 4;
   // Mode register field
   localparam int MODE_W = 2;
   // Pin config: bit 0 latched pushpull, bit 1 raw pushpull, +2 per cmp
   localparam int PIN_W = 4;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MUX_RST = 8'h00;
   localparam logic [1:0] MODE_RST = 2'h2;
   localparam logic [3:0] PIN_RST = 4'h0;
   // Synchroniser depth
   localparam int SYNC_STAGES = 2;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cmpw_pkg

// [design/cmpw_channel.sv]
// One comparator channel: synchroniser, edge detect, flags, outputs.
// Assumes the raw result comes straight from the analog core.
`timescale 1ns/100ps
`default_nettype none
module cmpw_channel
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Analog side
   input wire logic analog_result,
   input wire logic enable,
   // Flag clearing from software
   input wire logic clr_rise,
   input wire logic clr_fall,
   // Status
   output logic out_state,
   output logic rise_flag,
   output logic fall_flag,
   // Outputs
   output logic raw_out,
   output logic latched_out,
   output logic wake_req
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;
   logic rise_reg;
   logic fall_reg;

   // No clock on this path, so it works in stop and suspend
   assign raw_out = enable & analog_result;

   // First stage feeds only the second
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= enable & analog_result;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end
      else
      begin
         if (sync2_reg & ~prev_reg)
            rise_reg <= 1'b1;
         else if (clr_rise)
            rise_reg <= 1'b0;
         if (~sync2_reg & prev_reg)
            fall_reg <= 1'b1;
         else if (clr_fall)
            fall_reg <= 1'b0;
      end
   end

   assign out_state = sync2_reg;
   assign latched_out = sync2_reg;
   assign rise_flag = rise_reg;
   assign fall_flag = fall_reg;
   // Asynchronous so it can wake a stopped oscillator
   assign wake_req = enable & ~analog_result;
endmodule : cmpw_channel
`default_nettype wire

// [design/cmpw_top.sv]
// Dual comparator digital wrapper with an AXI4-Lite register slave.
// Assumes analog cores, pin drivers and the reset unit sit outside.
//
// Summary of operation
// - Two identical comparators; only zero resets system.
// - Latched and raw outputs available for pins.
// - Raw output works without any system clock.
// - Disabled comparator drives its pin outputs low.
// - Four-bit positive and negative input selects.
// - Result polled, interrupt, wake and pin sources.
// - Response time mode register forwarded to core.
// - Pin drivers selectable open-drain or push-pull.
// - Edges set sticky rise or fall flags.
// - Enable bit runs comparator; output always readable.
// - Enabled with output low wakes oscillator.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module cmpw_top
#(
   parameter int NUM_CMP = 2
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog core results
   input wire logic [1:0] cmp_result,
   // Analog core controls
   output logic [1:0] cmp_power_en,
   output logic [3:0] cmp0_pos_select,
   output logic [3:0] cmp0_neg_select,
   output logic [3:0] cmp1_pos_select,
   output logic [3:0] cmp1_neg_select,
   output logic [1:0] cmp0_response_mode,
   output logic [1:0] cmp1_response_mode,
   output logic [3:0] cmp0_hysteresis,
   output logic [3:0] cmp1_hysteresis,
   // Pin outputs, each with an enable; low enable means open-drain float
   output logic cmp0_latched_out,
   output logic cmp0_latched_oe,
   output logic cmp1_latched_out,
   output logic cmp1_latched_oe,
   output logic cmp0_raw_out,
   output logic cmp0_raw_oe,
   output logic cmp1_raw_out,
   output logic cmp1_raw_oe,
   // Events
   output logic [1:0] cmp_irq_req,
   output logic osc_wake_req,
   output logic sys_reset_req
);
   // Elaboration check: register map and pins exist for two only
   if (NUM_CMP != 2)
   begin : g_bad_num
      $error("cmpw_top serves exactly two comparators");
   end

   logic [7:0] ctrl_reg [2];
   logic [7:0] mux_reg [2];
   logic [1:0] mode_reg [2];
   logic [3:0] pin_reg;
   logic rst_en_reg;
   logic [1:0] clr_rise;
   logic [1:0] clr_fall;
   logic [1:0] out_state;
   logic [1:0] rise_flag;
   logic [1:0] fall_flag;
   logic [1:0] raw_o;
   logic [1:0] lat_o;
   logic [1:0] wake;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic do_write;

   function automatic int reg_index(input logic [7:0] a);
      unique case (a)
         cmpw_pkg::CTRL0_OFF: reg_index = 0;
         cmpw_pkg::MUX0_OFF: reg_index = 1;
         cmpw_pkg::MODE0_OFF: reg_index = 2;
         cmpw_pkg::CTRL1_OFF: reg_index = 3;
         cmpw_pkg::MUX1_OFF: reg_index = 4;
         cmpw_pkg::MODE1_OFF: reg_index = 5;
         cmpw_pkg::PIN_OFF: reg_index = 6;
         cmpw_pkg::RST_OFF: reg_index = 7;
         default: reg_index = -1;
      endcase
   endfunction : reg_index

   // Channel logic, repeated per comparator
   for (genvar i = 0; i < 2; i++)
   begin : g_ch
      cmpw_channel u_ch
      (
         .aclk(aclk),
         .aresetn(aresetn),
         .analog_result(cmp_result[i]),
         .enable(ctrl_reg[i][cmpw_pkg::CTRL_EN_BIT]),
         .clr_rise(clr_rise[i]),
         .clr_fall(clr_fall[i]),
         .out_state(out_state[i]),
         .rise_flag(rise_flag[i]),
         .fall_flag(fall_flag[i]),
         .raw_out(raw_o[i]),
         .latched_out(lat_o[i]),
         .wake_req(wake[i])
      );
      assign cmp_power_en[i] = ctrl_reg[i][cmpw_pkg::CTRL_EN_BIT];
      assign cmp_irq_req[i] = rise_flag[i] | fall_flag[i];
   end

   // Write channel: address and data taken in either order
   assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
   assign do_write = aw_hold_reg & w_hold_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= cmpw_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= (reg_index(awaddr_reg) < 0) ?
               cmpw_pkg::RESP_SLVERR : cmpw_pkg::RESP_OKAY;
         end
         else if (bvalid_reg & s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // Flags clear by writing one; only the low byte lane matters
   always_comb
   begin
      clr_rise = 2'b00;
      clr_fall = 2'b00;
      if (do_write & wstrb_reg[0])
      begin
         if (reg_index(awaddr_reg) == 0)
         begin
            clr_rise[0] = wdata_reg[cmpw_pkg::CTRL_RISE_BIT];
            clr_fall[0] = wdata_reg[cmpw_pkg::CTRL_FALL_BIT];
         end
         if (reg_index(awaddr_reg) == 3)
         begin
            clr_rise[1] = wdata_reg[cmpw_pkg::CTRL_RISE_BIT];
            clr_fall[1] = wdata_reg[cmpw_pkg::CTRL_FALL_BIT];
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg[0] <= cmpw_pkg::CTRL_RST;
         ctrl_reg[1] <= cmpw_pkg::CTRL_RST;
         mux_reg[0] <= cmpw_pkg::MUX_RST;
         mux_reg[1] <= cmpw_pkg::MUX_RST;
         mode_reg[0] <= cmpw_pkg::MODE_RST;
         mode_reg[1] <= cmpw_pkg::MODE_RST;
         pin_reg <= cmpw_pkg::PIN_RST;
         rst_en_reg <= 1'b0;
      end
      else if (do_write & wstrb_reg[0])
      begin
         unique case (reg_index(awaddr_reg))
            0: ctrl_reg[0] <= {wdata_reg[7], 3'b000, wdata_reg[3:0]};
            1: mux_reg[0] <= wdata_reg[7:0];
            2: mode_reg[0] <= wdata_reg[1:0];
            3: ctrl_reg[1] <= {wdata_reg[7], 3'b000, wdata_reg[3:0]};
            4: mux_reg[1] <= wdata_reg[7:0];
            5: mode_reg[1] <= wdata_reg[1:0];
            6: pin_reg <= wdata_reg[3:0];
            7: rst_en_reg <= wdata_reg[0];
            default: ;
         endcase
      end
   end

   function automatic logic [7:0] ctrl_view(input int i);
      ctrl_view = ctrl_reg[i];
      ctrl_view[cmpw_pkg::CTRL_OUT_BIT] = out_state[i];
      ctrl_view[cmpw_pkg::CTRL_RISE_BIT] = rise_flag[i];
      ctrl_view[cmpw_pkg::CTRL_FALL_BIT] = fall_flag[i];
   endfunction : ctrl_view

   // Read channel: one cycle to answer, held until taken
   assign s_axi_arready = ~rvalid_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= cmpw_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid & s_axi_arready)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg <= cmpw_pkg::RESP_OKAY;
         unique case (reg_index(s_axi_araddr))
            0: rdata_reg <= {24'h00_0000, ctrl_view(0)};
            1: rdata_reg <= {24'h00_0000, mux_reg[0]};
            2: rdata_reg <= {30'h0000_0000, mode_reg[0]};
            3: rdata_reg <= {24'h00_0000, ctrl_view(1)};
            4: rdata_reg <= {24'h00_0000, mux_reg[1]};
            5: rdata_reg <= {30'h0000_0000, mode_reg[1]};
            6: rdata_reg <= {28'h000_0000, pin_reg};
            7: rdata_reg <= {31'h0000_0000, rst_en_reg};
            default:
            begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= cmpw_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_reg & s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Analog core controls
   assign cmp0_pos_select = mux_reg[0][cmpw_pkg::MUX_POS_LSB +: 4];
   assign cmp0_neg_select = mux_reg[0][cmpw_pkg::MUX_NEG_LSB +: 4];
   assign cmp1_pos_select = mux_reg[1][cmpw_pkg::MUX_POS_LSB +: 4];
   assign cmp1_neg_select = mux_reg[1][cmpw_pkg::MUX_NEG_LSB +: 4];
   assign cmp0_response_mode = mode_reg[0];
   assign cmp1_response_mode = mode_reg[1];
   assign cmp0_hysteresis = ctrl_reg[0][cmpw_pkg::CTRL_HYS_LSB +: 4];
   assign cmp1_hysteresis = ctrl_reg[1][cmpw_pkg::CTRL_HYS_LSB +: 4];

   // Pins: push-pull drives always, open-drain only pulls low
   assign cmp0_latched_out = lat_o[0];
   assign cmp1_latched_out = lat_o[1];
   assign cmp0_raw_out = raw_o[0];
   assign cmp1_raw_out = raw_o[1];
   assign cmp0_latched_oe = pin_reg[0] | ~lat_o[0];
   assign cmp0_raw_oe = pin_reg[1] | ~raw_o[0];
   assign cmp1_latched_oe = pin_reg[2] | ~lat_o[1];
   assign cmp1_raw_oe = pin_reg[3] | ~raw_o[1];

   assign osc_wake_req = |wake;
   // Comparator one has no reset path
   assign sys_reset_req = rst_en_reg & ~lat_o[0];
endmodule : cmpw_top
`default_nettype wire

// [testbench/cmpw_chk_sva.sv]
// Port checker for the dual comparator wrapper.
// Assumes one clock; reset synchronous, active low.
`timescale 1ns/100ps
`default_nettype none
module cmpw_chk
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Comparator side
   input wire logic [1:0] cmp_result,
   input wire logic [1:0] cmp_power_en,
   input wire logic [1:0] cmp_irq_req,
   input wire logic cmp0_raw_out,
   input wire logic cmp1_raw_out,
   input wire logic cmp0_latched_out,
   input wire logic osc_wake_req,
   input wire logic sys_reset_req,
   // Bus answers
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Result as the synchroniser sees it
   logic [1:0] g;
   assign g = cmp_power_en & cmp_result;
   raw0_gate_a: assert property (cmp0_raw_out == g[0])
      else $error("raw output 0 wrong");
   raw1_gate_a: assert property (cmp1_raw_out == g[1])
      else $error("raw output 1 wrong");
   lat_off_a: assert property (
      !cmp_power_en[0] [*4] |-> !cmp0_latched_out)
      else $error("latched output high while off");
   // Rise needs a high result two edges back and a low one three back
   lat_sync_a: assert property ($rose(cmp0_latched_out) |->
      $past(g[0], 2) && !$past(g[0], 3))
      else $error("latched output rose too early");
   lat_on_a: assert property (g[0] [*4] |-> cmp0_latched_out)
      else $error("latched output missed high result");
   irq_edge_a: assert property ($rose(cmp_irq_req[0]) |->
      $past(g[0], 3) != $past(g[0], 4))
      else $error("flag set without an edge");
   wake_lvl_a: assert property (osc_wake_req ==
      |(cmp_power_en & ~cmp_result))
      else $error("wake request wrong");
   rst_src_a: assert property (sys_reset_req |-> !cmp0_latched_out)
      else $error("reset request without low output");
   rd_lat_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   cover property (g[0] ##1 !g[0]);
   cover property (sys_reset_req);
   cover property (osc_wake_req);
endmodule : cmpw_chk
bind cmpw_top cmpw_chk u_chk (.aclk, .aresetn, .cmp_result, .cmp_power_en,
   .cmp_irq_req, .cmp0_raw_out, .cmp1_raw_out, .cmp0_latched_out,
   .osc_wake_req, .sys_reset_req, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);
`default_nettype wire

// [testbench/cmpw_core_model.sv]
// Behavioural model of the two analog comparator cores.
// Assumes selects and power enables come from the wrapper.
`timescale 1ns/100ps
`default_nettype none
module cmpw_core_model
(
   // Core controls
   input wire logic [1:0] power_en,
   input wire logic [3:0] pos0,
   input wire logic [3:0] neg0,
   input wire logic [3:0] pos1,
   input wire logic [3:0] neg1,
   // Bench offset, flips a decision
   input wire logic [1:0] offset,
   // Decisions
   output logic [1:0] result
);
   // Inputs taken as plain analog levels
   // Unpowered core reads low, no stale level
   assign result[0] = power_en[0] & ((pos0 > neg0) ^ offset[0]);
   assign result[1] = power_en[1] & ((pos1 > neg1) ^ offset[1]);
endmodule : cmpw_core_model
`default_nettype wire

// [testbench/tb_cmpw_top.sv]
// Testbench for the dual comparator wrapper.
// Assumes the core model answers combinationally.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_cmpw_top;
   logic aclk = 1'b0, aresetn = 1'b0, run = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, osc_wake_req, sys_reset_req;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, ofs = 2'h0, cmp_result;
   logic [1:0] cmp_power_en, cmp0_response_mode, cmp1_response_mode;
   logic [1:0] cmp_irq_req;
   logic [3:0] cmp0_pos_select, cmp0_neg_select, cmp1_pos_select;
   logic [3:0] cmp1_neg_select, cmp0_hysteresis, cmp1_hysteresis;
   logic cmp0_latched_out, cmp0_latched_oe, cmp1_latched_out;
   logic cmp1_latched_oe, cmp0_raw_out, cmp0_raw_oe, cmp1_raw_out;
   logic cmp1_raw_oe;
   int error_cnt = 0, cmp_count = 0;
   always #4 if (run) aclk = ~aclk;
   cmpw_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_result,
      .cmp_power_en, .cmp0_pos_select, .cmp0_neg_select,
      .cmp1_pos_select, .cmp1_neg_select, .cmp0_response_mode,
      .cmp1_response_mode, .cmp0_hysteresis, .cmp1_hysteresis,
      .cmp0_latched_out, .cmp0_latched_oe, .cmp1_latched_out,
      .cmp1_latched_oe, .cmp0_raw_out, .cmp0_raw_oe, .cmp1_raw_out,
      .cmp1_raw_oe, .cmp_irq_req, .osc_wake_req, .sys_reset_req);
   cmpw_core_model u_core (.power_en(cmp_power_en),
      .pos0(cmp0_pos_select), .neg0(cmp0_neg_select),
      .pos1(cmp1_pos_select), .neg1(cmp1_neg_select),
      .offset(ofs), .result(cmp_result));
   task automatic give_verdict();
      if (error_cnt == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // Late bready exercises the held response
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axr
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      axr(a);
      `CHK(d, e)
      `CHK(r, cmpw_pkg::RESP_OKAY)
   endtask : rchk
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(cmpw_pkg::CTRL0_OFF, 32'h0000_0000);
      rchk(cmpw_pkg::MODE1_OFF, 32'h0000_0002);
      rchk(cmpw_pkg::PIN_OFF, 32'h0000_0000);
      axr(8'h30);
      `CHK({r, d}, {cmpw_pkg::RESP_SLVERR, 32'h0000_0000})
      axw(8'h30, 32'h0000_00FF);
      `CHK(r, cmpw_pkg::RESP_SLVERR)
      axw(cmpw_pkg::MUX0_OFF, 32'h0000_0021);
      `CHK(r, cmpw_pkg::RESP_OKAY)
      axw(cmpw_pkg::MUX1_OFF, 32'h0000_0012);
      axw(cmpw_pkg::MODE0_OFF, 32'h0000_0001);
      axw(cmpw_pkg::CTRL1_OFF, 32'h0000_0085);
      `CHK({cmp0_pos_select, cmp0_neg_select}, 8'h21)
      `CHK({cmp1_pos_select, cmp1_neg_select}, 8'h12)
      `CHK({cmp0_response_mode, cmp1_hysteresis}, 6'h15)
      `CHK(osc_wake_req, 1'b1)
      // Upper lanes only: the register must keep its value
      s_axi_wstrb <= 4'hE;
      axw(cmpw_pkg::MODE0_OFF, 32'h0000_0003);
      s_axi_wstrb <= 4'hF;
      `CHK({r, cmp0_response_mode, cmp1_response_mode}, 6'h06)
      axw(cmpw_pkg::CTRL0_OFF, 32'h0000_0080);
      repeat (4) @(posedge aclk);
      rchk(cmpw_pkg::CTRL0_OFF, 32'h0000_00E0);
      axw(cmpw_pkg::CTRL0_OFF, 32'h0000_00B3);
      rchk(cmpw_pkg::CTRL0_OFF, 32'h0000_00C3);
      `CHK(cmp0_hysteresis, 4'h3)
      `CHK({cmp_irq_req, cmp0_raw_out, cmp0_latched_out}, 4'h3)
      `CHK({cmp0_latched_oe, cmp1_latched_oe, cmp1_raw_oe}, 3'h3)
      axw(cmpw_pkg::PIN_OFF, 32'h0000_0003);
      `CHK({cmp0_latched_oe, cmp0_raw_oe}, 2'h3)
      // Clock held still, raw output must still follow
      @(negedge aclk) run = 1'b0;
      #20 ofs = 2'h1;
      #1 `CHK(cmp0_raw_out, 1'b0)
      ofs = 2'h0;
      #1 `CHK(cmp0_raw_out, 1'b1)
      run = 1'b1;
      axw(cmpw_pkg::RST_OFF, 32'h0000_0001);
      `CHK(sys_reset_req, 1'b0)
      axw(cmpw_pkg::MUX0_OFF, 32'h0000_0012);
      repeat (4) @(posedge aclk);
      `CHK({sys_reset_req, cmp_irq_req[0]}, 2'h3)
      rchk(cmpw_pkg::CTRL0_OFF, 32'h0000_0093);
      axw(cmpw_pkg::MUX0_OFF, 32'h0000_0021);
      repeat (4) @(posedge aclk);
      // Comparator 1 still low, yet no reset
      `CHK({sys_reset_req, cmp1_latched_out}, 2'h0)
      axw(cmpw_pkg::CTRL0_OFF, 32'h0000_0000);
      repeat (4) @(posedge aclk);
      `CHK({cmp0_raw_out, cmp0_latched_out, cmp_power_en}, 4'h2)
      axw(cmpw_pkg::CTRL1_OFF, 32'h0000_0000);
      `CHK(osc_wake_req, 1'b0)
      give_verdict();
   end
   initial
   begin
      #100000;
      error_cnt++;
      give_verdict();
   end
endmodule : tb_cmpw_top
`default_nettype wire
